// ===== rtl/apc_consts.svh
// Behaviour
// R1: One config register per analog-capable pin
// R2: Bits 2:0 select function, zero GPIO/converter
// R3: Bits 4:3 pull: none, down, up, repeater
// R4: Bit 6 inverts pin input when set
// R5: Bit 7 set digital, clear analog mode; pad analog_select is driven high when bit 7 is set
// R6: Bit 8 set bypasses the glitch filter
// R7: Bit 10 set gives simulated open drain
// R8: Software writes zero to reserved bits
// R9: Converter use: function zero, analog mode
// R10: Fields drive pads the cycle after write
`ifndef APC_CONSTS_SVH
`define APC_CONSTS_SVH

// ---------------------------------------------------------------
// Register map
// ---------------------------------------------------------------
`define APC_NUM_PINS       12
`define APC_ADDR_W         8
`define APC_REG_BASE       8'h00
`define APC_REG_STRIDE     8'h04
`define APC_CFG0_OFS       8'h00
`define APC_CFG1_OFS       8'h04
`define APC_CFG2_OFS       8'h08
`define APC_CFG3_OFS       8'h0c
`define APC_CFG4_OFS       8'h10
`define APC_CFG5_OFS       8'h14
`define APC_CFG6_OFS       8'h18
`define APC_CFG7_OFS       8'h1c
`define APC_CFG8_OFS       8'h20
`define APC_CFG9_OFS       8'h24
`define APC_CFG10_OFS      8'h28
`define APC_CFG11_OFS      8'h2c

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define APC_FSEL_LSB       0
`define APC_FSEL_MSB       2
`define APC_PULL_LSB       3
`define APC_PULL_MSB       4
`define APC_INV_BIT        6
`define APC_DIGI_BIT       7
`define APC_FOFF_BIT       8
`define APC_ODRAIN_BIT     10
`define APC_WRITE_MASK     32'h0000_05df

// ---------------------------------------------------------------
// Reset values and timing
// ---------------------------------------------------------------
`define APC_CFG_RESET      32'h0000_0190
`define APC_FILTER_NS      10
`define APC_CLK_MHZ        25

`endif

// ===== rtl/apc_pkg.sv
package apc_pkg;
   typedef enum logic [1:0] {
      APC_PULL_NONE = 2'h0,
      APC_PULL_DOWN = 2'h1,
      APC_PULL_UP   = 2'h2,
      APC_PULL_REP  = 2'h3
   } apc_pull_t;

   typedef struct packed {
      logic [2:0] function_select;
      apc_pull_t  pull;
      logic       invert;
      logic       analog_select;
      logic       glitch_filter_disable;
      logic       open_drain_enable;
   } apc_pad_ctl_t;
endpackage : apc_pkg

// ===== rtl/apc_pin_config_block.sv
// Chosen here: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "apc_consts.svh"

module apc_pin_config_block #(
   parameter int NUM_PINS = `APC_NUM_PINS
) (
   input  wire logic                      clk,
   input  wire logic                      rst,
   input  wire logic [`APC_ADDR_W-1:0]    addr,
   input  wire logic [31:0]               wdata,
   input  wire logic                      wr_stb,
   input  wire logic                      rd_stb,
   output logic      [31:0]               rdata,
   input  wire logic [NUM_PINS-1:0]       pin_in,
   output logic      [NUM_PINS-1:0]       function_in,
   output apc_pkg::apc_pad_ctl_t [NUM_PINS-1:0] pad_ctl,
   output logic      [NUM_PINS-1:0]       converter_channel_en
);
   import apc_pkg::*;

   // ------------------------------------------------------------
   // Register file
   // ------------------------------------------------------------
   logic [NUM_PINS-1:0][31:0] cfg_reg;
   logic [NUM_PINS-1:0][31:0] cfg_next;
   logic [31:0]               rdata_reg;
   logic [31:0]               rdata_next;
   logic [NUM_PINS-1:0]       sync1_reg;
   logic [NUM_PINS-1:0]       sync2_reg;
   logic [NUM_PINS-1:0]       sync3_reg;
   logic [NUM_PINS-1:0]       filt_reg;
   logic [NUM_PINS-1:0]       filt_next;

   // Word index, or NUM_PINS when unmapped or unaligned
   function automatic int unsigned reg_index(
      input logic [`APC_ADDR_W-1:0] a);
      int unsigned idx;
      if (a == `APC_CFG0_OFS) begin
         idx = 0;
      end else if (a == `APC_CFG1_OFS) begin
         idx = 1;
      end else if (a == `APC_CFG2_OFS) begin
         idx = 2;
      end else if (a == `APC_CFG3_OFS) begin
         idx = 3;
      end else if (a == `APC_CFG4_OFS) begin
         idx = 4;
      end else if (a == `APC_CFG5_OFS) begin
         idx = 5;
      end else if (a == `APC_CFG6_OFS) begin
         idx = 6;
      end else if (a == `APC_CFG7_OFS) begin
         idx = 7;
      end else if (a == `APC_CFG8_OFS) begin
         idx = 8;
      end else if (a == `APC_CFG9_OFS) begin
         idx = 9;
      end else if (a == `APC_CFG10_OFS) begin
         idx = 10;
      end else if (a == `APC_CFG11_OFS) begin
         idx = 11;
      end else begin
         idx = NUM_PINS;
      end
      return idx;
   endfunction : reg_index

   // Field extraction shared by pad and input paths
   function automatic logic [2:0] fsel_of(input logic [31:0] r);
      return r[`APC_FSEL_MSB:`APC_FSEL_LSB];
   endfunction : fsel_of

   function automatic logic invert_of(input logic [31:0] r);
      return r[`APC_INV_BIT];
   endfunction : invert_of

   function automatic logic digital_of(input logic [31:0] r);
      return r[`APC_DIGI_BIT];
   endfunction : digital_of

   function automatic logic bypass_of(input logic [31:0] r);
      return r[`APC_FOFF_BIT];
   endfunction : bypass_of

   always_comb begin
      cfg_next   = cfg_reg;
      rdata_next = 32'h0000_0000;
      if (wr_stb && reg_index(addr) < NUM_PINS) begin
         // Reserved bits kept zero so reads stay clean [R8] [R1]
         cfg_next[reg_index(addr)] = wdata & `APC_WRITE_MASK;
      end
      if (rd_stb && reg_index(addr) < NUM_PINS) begin
         rdata_next = cfg_reg[reg_index(addr)];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < NUM_PINS; i++) begin
            cfg_reg[i] <= `APC_CFG_RESET; // [R1]
         end
         rdata_reg <= 32'h0000_0000;
      end else begin
         cfg_reg   <= cfg_next;
         rdata_reg <= rdata_next;
      end
   end

   assign rdata = rdata_reg;

   // ------------------------------------------------------------
   // Pad controls
   // ------------------------------------------------------------
   always_comb begin
      for (int i = 0; i < NUM_PINS; i++) begin
         // Straight from flops, so effect starts after the write [R10]
         pad_ctl[i].function_select = fsel_of(cfg_reg[i]); // [R2]
         pad_ctl[i].pull = apc_pull_t'(
            cfg_reg[i][`APC_PULL_MSB:`APC_PULL_LSB]); // [R3]
         pad_ctl[i].invert = invert_of(cfg_reg[i]); // [R4]
         pad_ctl[i].analog_select = digital_of(cfg_reg[i]); // analog_select follows bit 7: high in digital mode, low in analog mode [R5]
         pad_ctl[i].glitch_filter_disable = bypass_of(cfg_reg[i]); // [R6]
         pad_ctl[i].open_drain_enable =
            cfg_reg[i][`APC_ODRAIN_BIT]; // [R7]
         // Converter path needs function zero and analog mode [R9] [R2]
         converter_channel_en[i] =
            (fsel_of(cfg_reg[i]) == 3'h0) && !digital_of(cfg_reg[i]);
      end
   end

   // ------------------------------------------------------------
   // Input path
   // ------------------------------------------------------------
   // One 40 ns clock already exceeds the 10 ns glitch span, so a
   // single agreeing-sample stage serves as the filter.
   always_comb begin
      for (int i = 0; i < NUM_PINS; i++) begin
         // First stage never read here: metastability stays contained
         filt_next[i] = filt_reg[i];
         if (sync3_reg[i] == sync2_reg[i]) begin
            filt_next[i] = sync2_reg[i];
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
         sync3_reg <= '0;
         filt_reg  <= '0;
      end else begin
         sync1_reg <= pin_in;
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
         filt_reg  <= filt_next;
      end
   end

   always_comb begin
      for (int i = 0; i < NUM_PINS; i++) begin
         // Analog mode blocks the digital input [R5]
         if (!digital_of(cfg_reg[i])) begin
            function_in[i] = 1'b0;
         end else if (bypass_of(cfg_reg[i])) begin
            function_in[i] =
               sync2_reg[i] ^ invert_of(cfg_reg[i]); // [R6] [R4]
         end else begin
            function_in[i] =
               filt_reg[i] ^ invert_of(cfg_reg[i]); // [R6] [R4]
         end
      end
   end
endmodule : apc_pin_config_block

// ===== testbench/apc_cfg_sva.sv
`timescale 1ns/1ps
// ----
// Checks
// ----
module apc_cfg_sva #(parameter int NUM_PINS = 12) (
   input logic clk, rst, wr_stb, rd_stb,
   input logic [7:0] addr,
   input logic [31:0] wdata, rdata,
   input logic [NUM_PINS-1:0] pin_in, function_in, converter_channel_en,
   input apc_pkg::apc_pad_ctl_t [NUM_PINS-1:0] pad_ctl
);
   import apc_pkg::*;
   wire apc_pad_ctl_t c0 = pad_ctl[0];
   wire w0 = wr_stb && addr == 8'h0;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   property p_wr; w0 |=> c0 == $past({wdata[2:0], wdata[4:3], wdata[6],
      wdata[7], wdata[8], wdata[10]}); endproperty
   a_wr: assert property (p_wr) else $error("wr");
   property p_hold; !w0 |=> $stable(c0); endproperty
   a_hold: assert property (p_hold) else $error("hold");
   property p_bad; wr_stb && addr == 8'h30 |=> $stable(pad_ctl); endproperty
   a_bad: assert property (p_bad) else $error("bad");
   property p_rd; rd_stb && !addr |=> rdata[2:0] == c0[8:6]; endproperty
   a_rd: assert property (p_rd) else $error("rd");
   property p_idle; !rd_stb |=> !rdata; endproperty
   a_idle: assert property (p_idle) else $error("idle");
   property p_conv; converter_channel_en[0] == (!c0[8:6] && !c0[2]);
   endproperty
   a_conv: assert property (p_conv) else $error("conv");
   property p_ana; !c0[2] |-> !function_in[0]; endproperty
   a_ana: assert property (p_ana) else $error("ana");
   property p_inv; (c0[2] && c0[1] && $stable(pin_in[0]))[*3] |->
      function_in[0] == (pin_in[0] ^ c0[3]); endproperty
   a_inv: assert property (p_inv) else $error("inv");
   cover property (w0);
   cover property (rd_stb);
   cover property (converter_channel_en[0]);
endmodule : apc_cfg_sva

// ===== testbench/apc_pin_config_block_tb.sv
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin \
   num_errors++; $display("[FAIL] %0t mismatch", $time); end end
bind apc_pin_config_block apc_cfg_sva #(.NUM_PINS(NUM_PINS)) u_sva (.*);
// ----
// Bench
// ----
module apc_pin_config_block_tb;
   import apc_pkg::*;
   logic clk = 0, rst = 1, wr_stb = 0, rd_stb = 0;
   logic [7:0] addr = 8'h0;
   logic [31:0] wdata = 32'h0, rdata, v, m[12] = '{default: 32'h190};
   logic [11:0] pin_in = 12'h0, function_in, converter_channel_en;
   apc_pad_ctl_t [11:0] pad_ctl;
   int num_errors = 0, total_checks = 0;
   apc_pin_config_block dut (.*);
   initial forever #20 clk = ~clk;
   task automatic bus(int n, logic w, logic [31:0] d);
      @(posedge clk);
      addr <= 8'(4 * n);
      wdata <= d;
      wr_stb <= w;
      rd_stb <= !w;
      @(posedge clk);
      {wr_stb, rd_stb} <= 2'h0;
      if (w && n < 12) m[n] = d & 32'h5df;
      #1 if (!w) `CHK(rdata, n < 12 ? m[n] : 32'h0)
   endtask : bus
   task automatic summarize();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : summarize
   initial begin
      void'($urandom(42));
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 13; i++) bus(i, 0, 0);
      $display("reset test done");
      for (int i = 0; i < 13; i++) begin
         v = i % 8 | i % 4 << 3 | i[0] << 6 | (i > 3) << 7 | (i > 7) << 8;
         bus(i, 1, v | $urandom & 32'h400);
         if (i < 12) `CHK(converter_channel_en[i], !v[2:0] && !v[7])
         bus(i, 0, 0);
      end
      $display("write test done");
      pin_in <= 12'($urandom);
      repeat (4) @(posedge clk);
      #1 for (int i = 0; i < 12; i++) `CHK(function_in[i],
         m[i][7] & (pin_in[i] ^ m[i][6]))
      $display("input test done");
      summarize();
   end
endmodule : apc_pin_config_block_tb
